// [design/awsc_pkg.sv]
`default_nettype none
package awsc_pkg;
	// ***************************************************
	// opcodes handled by this block
	// ***************************************************
	localparam logic [7:0] OP_STBY_IMM_A = 8'h94;
	localparam logic [7:0] OP_STBY_IMM_B = 8'he0;
	localparam logic [7:0] OP_TRANSLATE  = 8'h87;
	localparam logic [7:0] OP_WR_BUF     = 8'he8;
	localparam logic [7:0] OP_WR_DMA     = 8'hca;
	localparam logic [7:0] OP_WR_MULT    = 8'hc5;
	localparam logic [7:0] OP_WR_MULT_NE = 8'hcd;
	localparam logic [7:0] OP_SET_MULT   = 8'hc6;

	// ***************************************************
	// sizes, fields, reset values
	// ***************************************************
	localparam int          DATA_W          = 16;
	localparam int          WORD_IDX_W      = 8;
	localparam logic [7:0]  LAST_WORD_IDX   = 8'hff;
	localparam logic [8:0]  CNT_ZERO_AS     = 9'h100;
	localparam int          DH_LBA_BIT      = 6;
	localparam int          DH_DEV_BIT      = 4;
	localparam logic [7:0]  BLOCK_SUPPORTED = 8'h01;
	localparam logic [7:0]  RST_BLOCK_SIZE  = 8'h00;
	localparam logic        RST_MULT_EN     = 1'b0;
	localparam logic [7:0]  SEC_CNT_NONE    = 8'h00;

	// ***************************************************
	// timing at 125 MHz
	// ***************************************************
	localparam int CLK_PERIOD_PS = 8000;
	localparam int BSY_MAX_NS    = 400;
	localparam int BSY_MAX_CYC   = (BSY_MAX_NS * 1000) / CLK_PERIOD_PS;
endpackage
`default_nettype wire

// [design/awsc_word_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface awsc_word_if;
	logic        word_stb;
	logic [15:0] word_data;
	logic        dma_ack;
	modport src (output word_stb, output word_data, output dma_ack);
	modport dst (input word_stb, input word_data, input dma_ack);
endinterface
`default_nettype wire

// [design/awsc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module awsc_sync (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// host pins
	input  wire logic        i_iowr_n,
	input  wire logic        i_dmack_n,
	input  wire logic [15:0] i_data,
	// word stream
	awsc_word_if.src         o_word
);
	logic [2:0]  iowr_s;
	logic [2:0]  dmack_s;
	logic [15:0] data_s [3];
	logic        iowr_filt;
	logic        dmack_filt;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			iowr_s  <= 3'h7;
			dmack_s <= 3'h7;
		end else begin
			iowr_s  <= {iowr_s[1:0], i_iowr_n};
			dmack_s <= {dmack_s[1:0], i_dmack_n};
		end
	end

	// data follows the strobe's delay so the word lines up with its edge
	always_ff @(posedge i_clk) begin
		data_s[0] <= i_data;
		data_s[1] <= data_s[0];
		data_s[2] <= data_s[1];
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			iowr_filt  <= 1'b1;
			dmack_filt <= 1'b1;
		end else begin
			if (iowr_s[1] == iowr_s[2])
				iowr_filt <= iowr_s[2];
			if (dmack_s[1] == dmack_s[2])
				dmack_filt <= dmack_s[2];
		end
	end

	// word taken on the closing edge of the write strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_word.word_stb  <= 1'b0;
			o_word.word_data <= 16'h0000;
		end else begin
			o_word.word_stb <= !iowr_filt && iowr_s[1] && iowr_s[2];
			if (!iowr_filt && iowr_s[1] && iowr_s[2])
				o_word.word_data <= data_s[2];
		end
	end

	assign o_word.dma_ack = !dmack_filt;
endmodule // awsc_sync
`default_nettype wire

// [design/awsc_wcnt.sv]
`timescale 1ns/1ps
`default_nettype none
module awsc_wcnt #(
	parameter int IDX_W = 8
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// control
	input  wire logic             i_clr,
	input  wire logic             i_stb,
	// position
	output logic      [IDX_W-1:0] o_idx,
	output logic                  o_last
);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_idx <= '0;
		else if (i_clr)
			o_idx <= '0;
		else if (i_stb)
			o_idx <= o_idx + 1'b1;
	end

	// wraps by itself after a full sector
	assign o_last = i_stb && (o_idx == {IDX_W{1'b1}});
endmodule // awsc_wcnt
`default_nettype wire

// [design/awsc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module awsc_top (
	// clock and reset
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_arst_n,
	// command and task file
	input  wire logic                         i_cmd_valid,
	input  wire logic [7:0]                   i_cmd_opcode,
	input  wire logic [7:0]                   i_tf_sec_cnt,
	input  wire logic [7:0]                   i_tf_sec_num,
	input  wire logic [7:0]                   i_tf_cyl_lo,
	input  wire logic [7:0]                   i_tf_cyl_hi,
	input  wire logic [7:0]                   i_tf_dev_head,
	input  wire logic                         i_xfer8_en,
	// host data pins
	input  wire logic                         i_iowr_n,
	input  wire logic                         i_dmack_n,
	input  wire logic [awsc_pkg::DATA_W-1:0]  i_data,
	// status and task file readback
	output logic                              o_bsy,
	output logic                              o_drq,
	output logic                              o_dmarq,
	output logic                              o_irq,
	output logic                              o_err,
	output logic                              o_abrt,
	output logic                              o_sleep,
	output logic [7:0]                        o_sec_cnt,
	output logic [7:0]                        o_sec_num,
	output logic [7:0]                        o_cyl_lo,
	output logic [7:0]                        o_cyl_hi,
	output logic [7:0]                        o_dev_head,
	output logic                              o_mult_en,
	output logic [7:0]                        o_block_size,
	output logic [7:0]                        o_id_block_max,
	// sector buffer
	output logic                              o_buf_we,
	output logic [awsc_pkg::WORD_IDX_W-1:0]   o_buf_addr,
	output logic [awsc_pkg::DATA_W-1:0]       o_buf_data,
	// media commit
	output logic                              o_sec_wr,
	output logic [27:0]                       o_sec_lba,
	output logic                              o_no_erase,
	input  wire logic                         i_sec_ack,
	input  wire logic                         i_sec_err
);
	import awsc_pkg::*;

	// ***************************************************
	// types and state
	// ***************************************************
	typedef enum {S_IDLE, S_BUSY, S_XFER, S_COMMIT} awsc_state_e;
	typedef enum {K_STBY, K_NOP, K_SETM, K_ABRT, K_WRBUF, K_DMA, K_MULT} awsc_kind_e;

	localparam int BSY_LIM = BSY_MAX_CYC;

	awsc_state_e                   state_reg;
	awsc_kind_e                    kind_reg;
	logic [1:0]                    rst_sync;
	logic                          rst_n;
	logic [27:0]                   lba_reg;
	logic [3:0]                    dh_hi_reg;
	logic [8:0]                    remain_reg;
	logic [7:0]                    blk_left_reg;
	logic [7:0]                    setm_cnt_reg;
	logic                          accept;
	logic                          word_ok;
	logic                          word_last;
	logic [WORD_IDX_W-1:0]         word_idx;
	logic                          commit_ok;
	logic                          commit_bad;
	logic [7:0]                    next_blk;
	logic [7:0]                    remain_lo;

	awsc_word_if word_if ();

	function automatic logic is_standby(input logic [7:0] op);
		return (op == OP_STBY_IMM_A) || (op == OP_STBY_IMM_B);
	endfunction

	function automatic logic is_mult(input logic [7:0] op);
		return (op == OP_WR_MULT) || (op == OP_WR_MULT_NE);
	endfunction

	// ***************************************************
	// reset release
	// ***************************************************
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ***************************************************
	// host word path
	// ***************************************************
	awsc_sync u_sync (
		.i_clk     (i_clk_sys),
		.i_rst_n   (rst_n),
		.i_iowr_n  (i_iowr_n),
		.i_dmack_n (i_dmack_n),
		.i_data    (i_data),
		.o_word    (word_if.src)
	);

	// dma words only count while the host acknowledges
	assign word_ok = (state_reg == S_XFER) && word_if.word_stb && ((kind_reg != K_DMA) || word_if.dma_ack);

	awsc_wcnt #(.IDX_W(WORD_IDX_W)) u_wcnt (
		.i_clk   (i_clk_sys),
		.i_rst_n (rst_n),
		.i_clr   (state_reg != S_XFER),
		.i_stb   (word_ok),
		.o_idx   (word_idx),
		.o_last  (word_last)
	);

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_buf_we   <= 1'b0;
			o_buf_addr <= '0;
			o_buf_data <= '0;
		end else begin
			o_buf_we <= word_ok;
			if (word_ok) begin
				o_buf_addr <= word_idx;
				o_buf_data <= word_if.word_data;
			end
		end
	end

	// ***************************************************
	// command sequencer
	// ***************************************************
	assign accept     = i_cmd_valid && (state_reg == S_IDLE);
	assign commit_ok  = (state_reg == S_COMMIT) && i_sec_ack && !i_sec_err;
	assign commit_bad = (state_reg == S_COMMIT) && i_sec_ack && i_sec_err;
	assign remain_lo  = remain_reg[7:0];
	// partial block when fewer sectors remain than a block holds
	assign next_blk   = ((remain_reg - 9'h001) < {1'b0, o_block_size})
		? 8'((remain_reg - 9'h001)) : o_block_size;

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			kind_reg  <= K_NOP;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (accept) begin
						state_reg <= S_BUSY;
						// only the opcode and the fields it uses are looked at
						if (is_standby(i_cmd_opcode))
							kind_reg <= K_STBY;
						else if (i_cmd_opcode == OP_TRANSLATE)
							kind_reg <= K_NOP;
						else if (i_cmd_opcode == OP_SET_MULT)
							kind_reg <= K_SETM;
						else if (i_cmd_opcode == OP_WR_BUF)
							kind_reg <= K_WRBUF;
						else if (i_cmd_opcode == OP_WR_DMA)
							kind_reg <= i_xfer8_en ? K_ABRT : K_DMA;
						else if (is_mult(i_cmd_opcode))
							kind_reg <= o_mult_en ? K_MULT : K_ABRT;
						else
							state_reg <= S_IDLE;
					end
				end
				S_BUSY: begin
					if ((kind_reg == K_WRBUF) || (kind_reg == K_DMA) || (kind_reg == K_MULT))
						state_reg <= S_XFER;
					else
						state_reg <= S_IDLE;
				end
				S_XFER: begin
					if (word_last)
						state_reg <= (kind_reg == K_WRBUF) ? S_IDLE : S_COMMIT;
				end
				S_COMMIT: begin
					// a failing sector ends the command, even mid block
					if (commit_bad || (commit_ok && (remain_reg == 9'h001)))
						state_reg <= S_IDLE;
					else if (commit_ok)
						state_reg <= S_XFER;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// ***************************************************
	// address, counts, block tracking
	// ***************************************************
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lba_reg      <= '0;
			dh_hi_reg    <= 4'h0;
			remain_reg   <= '0;
			blk_left_reg <= '0;
			setm_cnt_reg <= '0;
			o_no_erase   <= 1'b0;
		end else if (accept) begin
			setm_cnt_reg <= i_tf_sec_cnt;
			if ((i_cmd_opcode == OP_WR_DMA) || is_mult(i_cmd_opcode)) begin
				// lba flag and device bit kept as given
				lba_reg    <= {i_tf_dev_head[3:0], i_tf_cyl_hi, i_tf_cyl_lo, i_tf_sec_num};
				dh_hi_reg  <= i_tf_dev_head[7:4];
				remain_reg <= (i_tf_sec_cnt == 8'h00) ? CNT_ZERO_AS : {1'b0, i_tf_sec_cnt};
				o_no_erase <= (i_cmd_opcode == OP_WR_MULT_NE);
			end else
				remain_reg <= 9'h001;
		end else if ((state_reg == S_BUSY) && (kind_reg == K_MULT)) begin
			blk_left_reg <= ({1'b0, o_block_size} < remain_reg) ? o_block_size : remain_reg[7:0];
		end else if (commit_ok && (remain_reg != 9'h001)) begin
			// last sector's address is left in place on completion
			lba_reg    <= lba_reg + 28'h0000001;
			remain_reg <= remain_reg - 9'h001;
			blk_left_reg <= (blk_left_reg == 8'h01) ? next_blk : blk_left_reg - 8'h01;
		end else if (commit_ok) begin
			remain_reg <= 9'h000;
		end
	end

	// ***************************************************
	// multiple mode setting
	// ***************************************************
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_mult_en    <= RST_MULT_EN;
			o_block_size <= RST_BLOCK_SIZE;
		end else if ((state_reg == S_BUSY) && (kind_reg == K_SETM)) begin
			// zero or an unsupported size leaves multiple disabled
			o_mult_en    <= (setm_cnt_reg != 8'h00) && (setm_cnt_reg <= BLOCK_SUPPORTED);
			o_block_size <= ((setm_cnt_reg != 8'h00) && (setm_cnt_reg <= BLOCK_SUPPORTED))
				? setm_cnt_reg : RST_BLOCK_SIZE;
		end
	end
	assign o_id_block_max = BLOCK_SUPPORTED;

	// ***************************************************
	// status, interrupt, sleep
	// ***************************************************
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_irq     <= 1'b0;
			o_err     <= 1'b0;
			o_abrt    <= 1'b0;
			o_sleep   <= 1'b0;
			o_sec_cnt <= SEC_CNT_NONE;
		end else begin
			o_irq <= 1'b0;
			if (i_cmd_valid)
				o_sleep <= 1'b0;
			if (accept) begin
				o_err  <= 1'b0;
				o_abrt <= 1'b0;
			end
			if (state_reg == S_BUSY) begin
				case (kind_reg)
					K_STBY: begin
						o_sleep <= 1'b1;
						o_irq   <= 1'b1;
					end
					K_NOP: begin
						o_sec_cnt <= SEC_CNT_NONE;
						o_irq     <= 1'b1;
					end
					K_SETM: begin
						o_irq  <= 1'b1;
						o_err  <= (setm_cnt_reg > BLOCK_SUPPORTED);
						o_abrt <= (setm_cnt_reg > BLOCK_SUPPORTED);
					end
					K_ABRT: begin
						o_err  <= 1'b1;
						o_abrt <= 1'b1;
						o_irq  <= 1'b1;
					end
					default: o_irq <= 1'b0; // first buffer is requested without interrupt
				endcase
			end
			if ((state_reg == S_XFER) && word_last && (kind_reg == K_WRBUF))
				o_irq <= 1'b1;
			if (commit_bad) begin
				o_err     <= 1'b1;
				o_sec_cnt <= remain_lo; // outstanding including failing sector
				o_irq     <= 1'b1;
			end else if (commit_ok && (remain_reg == 9'h001)) begin
				o_sec_cnt <= SEC_CNT_NONE;
				o_irq     <= 1'b1;
			end else if (commit_ok && (kind_reg == K_MULT) && (blk_left_reg == 8'h01))
				o_irq <= 1'b1;
		end
	end

	// media sees one pulse per finished sector
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n)
			o_sec_wr <= 1'b0;
		else
			o_sec_wr <= (state_reg == S_XFER) && word_last && (kind_reg != K_WRBUF);
	end

	assign o_bsy      = (state_reg == S_BUSY) || (state_reg == S_COMMIT);
	assign o_drq      = (state_reg == S_XFER);
	assign o_dmarq    = (state_reg == S_XFER) && (kind_reg == K_DMA);
	assign o_sec_lba  = lba_reg;
	assign o_sec_num  = lba_reg[7:0];
	assign o_cyl_lo   = lba_reg[15:8];
	assign o_cyl_hi   = lba_reg[23:16];
	assign o_dev_head = {dh_hi_reg, lba_reg[27:24]};

	// ***************************************************
	// assertions
	// ***************************************************
	sequence s_busy_then_sleep;
		o_bsy ##1 (!o_bsy && o_sleep && o_irq);
	endsequence

	property p_stby;
		@(posedge i_clk_sys) disable iff (!rst_n) (accept && is_standby(i_cmd_opcode)) |=> s_busy_then_sleep;
	endproperty
	a_stby: assert property (p_stby) else $error("standby did not sleep and interrupt");

	property p_wake;
		@(posedge i_clk_sys) disable iff (!rst_n) (o_sleep && i_cmd_valid) |=> !o_sleep;
	endproperty
	a_wake: assert property (p_wake) else $error("command did not wake device");

	property p_trans;
		@(posedge i_clk_sys) disable iff (!rst_n) (accept && (i_cmd_opcode == OP_TRANSLATE)) |=> ##1 (o_sec_cnt == 8'h00 && o_irq);
	endproperty
	a_trans: assert property (p_trans) else $error("translate did not return zero");

	property p_cnt0;
		@(posedge i_clk_sys) disable iff (!rst_n) (accept && (i_cmd_opcode == OP_WR_DMA) && (i_tf_sec_cnt == 8'h00)) |=> (remain_reg == 9'h100);
	endproperty
	a_cnt0: assert property (p_cnt0) else $error("zero count not taken as 256");

	sequence s_busy_then_dmarq;
		o_bsy ##1 (o_dmarq && o_drq && !o_bsy);
	endsequence

	property p_dma_start;
		@(posedge i_clk_sys) disable iff (!rst_n) (accept && (i_cmd_opcode == OP_WR_DMA) && !i_xfer8_en) |=> s_busy_then_dmarq;
	endproperty
	a_dma_start: assert property (p_dma_start) else $error("dma write start sequence wrong");

	property p_dma_noirq;
		@(posedge i_clk_sys) disable iff (!rst_n) (commit_ok && (kind_reg == K_DMA) && (remain_reg != 9'h001)) |=> !o_irq;
	endproperty
	a_dma_noirq: assert property (p_dma_noirq) else $error("dma write interrupted per sector");

	property p_abrt8;
		@(posedge i_clk_sys) disable iff (!rst_n) (accept && (i_cmd_opcode == OP_WR_DMA) && i_xfer8_en) |=> ##1 (o_abrt && o_err && o_irq && !o_dmarq);
	endproperty
	a_abrt8: assert property (p_abrt8) else $error("8-bit dma write not aborted");

	property p_bsy400;
		@(posedge i_clk_sys) disable iff (!rst_n) (accept && is_mult(i_cmd_opcode)) |-> ##[1:BSY_LIM] o_bsy;
	endproperty
	a_bsy400: assert property (p_bsy400) else $error("busy late after multiple write");

	property p_mblk;
		@(posedge i_clk_sys) disable iff (!rst_n) (commit_ok && (kind_reg == K_MULT) && (remain_reg != 9'h001) && (blk_left_reg != 8'h01)) |=> (!o_irq && o_drq);
	endproperty
	a_mblk: assert property (p_mblk) else $error("interrupt inside a block");

	property p_err_res;
		@(posedge i_clk_sys) disable iff (!rst_n) commit_bad |=> (o_err && o_irq && (o_sec_cnt == $past(remain_lo)) && !o_bsy && (o_sec_lba == $past(lba_reg)));
	endproperty
	a_err_res: assert property (p_err_res) else $error("error residue or address wrong");

	property p_setm0;
		@(posedge i_clk_sys) disable iff (!rst_n) (accept && (i_cmd_opcode == OP_SET_MULT) && (i_tf_sec_cnt == 8'h00)) |=> ##1 (!o_mult_en && !o_abrt);
	endproperty
	a_setm0: assert property (p_setm0) else $error("zero block size did not disable");
endmodule // awsc_top
`default_nettype wire

// [testbench/awsc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// host adapter: data pins and strobes
// ************************************************
module awsc_host_model (
	// clock
	input  wire logic        i_clk,
	// host pins
	output logic             o_iowr_n,
	output logic             o_dmack_n,
	output logic [15:0]      o_data
);
	initial begin
		o_iowr_n  = 1'b1;
		o_dmack_n = 1'b1;
		o_data    = 16'h0000;
	end
	// one sector, one strobe per 16-bit word; data held past the rising edge for the filter
	task automatic send_words(input bit dma, input logic [15:0] base);
		for (int i = 0; i < 256; i++) begin
			@(negedge i_clk);
			o_dmack_n = !dma;
			o_data    = base + 16'(i);
			repeat (4) @(negedge i_clk);
			o_iowr_n = 1'b0;
			repeat (4) @(negedge i_clk);
			o_iowr_n = 1'b1;
			repeat (4) @(negedge i_clk);
		end
		// a released bus must not keep showing the last word
		o_dmack_n = 1'b1;
		o_data    = ~o_data;
	endtask
endmodule // awsc_host_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// bench for the write and standby command block
// ************************************************
module tb_top;
	typedef struct packed {logic [7:0] op; logic [7:0] cnt; logic x8; logic abrt; logic slp; logic men;} awsc_row_s;
	logic        clk, arst_n, cmd_v, x8, iowr_n, dmack_n;
	logic        sec_ack = 1'b0;
	logic        sec_err = 1'b0;
	logic [7:0]  op, cnt, snum, clo, chi, dh;
	logic [15:0] dat, bdata, ld;
	logic        bsy, drq, dmarq, irq, err, abrt, slp, men, buf_we, sec_wr, no_erase, ne;
	logic [7:0]  o_cnt, o_snum, o_clo, o_chi, o_dh, bsz, idmax, baddr, la;
	logic [27:0] slba, fl;
	logic [2:0]  dly = 3'h0;
	int          fails = 0;
	int          checks = 0;
	int          irq_n = 0;
	int          bufs = 0;
	int          sec_idx = 0;
	int          err_at = -1;
	int          n;
	awsc_row_s   rows [9] = '{20'h94002, 20'h87050, 20'he0002, 20'hc5024, 20'hca00c,
		20'hc6024, 20'hc6011, 20'hc6000, 20'hc6011};

	awsc_top awsc_top_i (.i_clk_sys(clk), .i_arst_n(arst_n), .i_cmd_valid(cmd_v), .i_cmd_opcode(op),
		.i_tf_sec_cnt(cnt), .i_tf_sec_num(snum), .i_tf_cyl_lo(clo), .i_tf_cyl_hi(chi), .i_tf_dev_head(dh),
		.i_xfer8_en(x8), .i_iowr_n(iowr_n), .i_dmack_n(dmack_n), .i_data(dat), .o_bsy(bsy), .o_drq(drq),
		.o_dmarq(dmarq), .o_irq(irq), .o_err(err), .o_abrt(abrt), .o_sleep(slp), .o_sec_cnt(o_cnt),
		.o_sec_num(o_snum), .o_cyl_lo(o_clo), .o_cyl_hi(o_chi), .o_dev_head(o_dh), .o_mult_en(men),
		.o_block_size(bsz), .o_id_block_max(idmax), .o_buf_we(buf_we), .o_buf_addr(baddr), .o_buf_data(bdata),
		.o_sec_wr(sec_wr), .o_sec_lba(slba), .o_no_erase(no_erase), .i_sec_ack(sec_ack), .i_sec_err(sec_err));
	awsc_host_model awsc_host_model_i (.i_clk(clk), .o_iowr_n(iowr_n), .o_dmack_n(dmack_n), .o_data(dat));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ************************************************
	// monitors and media responder
	// ************************************************
	always @(posedge clk) begin
		if (irq === 1'b1) irq_n++;
		if (buf_we === 1'b1) begin
			bufs++;
			la = baddr;
			ld = bdata;
		end
	end
	// media answers three cycles after each commit, failing on one chosen sector
	always @(negedge clk) begin
		dly <= {dly[1:0], sec_wr === 1'b1};
		sec_ack <= dly[2];
		sec_err <= dly[2] && (sec_idx == err_at);
		if (dly[2]) sec_idx <= sec_idx + 1;
		if (sec_wr === 1'b1 && sec_idx == 0) fl <= slba;
		if (sec_wr === 1'b1) ne <= no_erase;
	end
	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input string nm, input logic [27:0] exp, input logic [27:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cmd(input logic [7:0] o, input logic [7:0] c, input logic [27:0] lba);
		@(negedge clk);
		cmd_v = 1'b1;
		op = o;
		cnt = c;
		{dh[3:0], chi, clo, snum} = lba;
		dh[7:4] = 4'he;
		@(negedge clk);
		cmd_v = 1'b0;
	endtask
	task automatic wait_irq(input int want);
		for (int k = 0; k < 20000 && irq_n < want; k++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk("irq count", 28'(want), 28'(irq_n));
	endtask
	task automatic run(input logic [7:0] o, input logic [7:0] c, input int ns, input bit dma,
		input logic [27:0] lba, input int ea);
		err_at = ea;
		sec_idx = 0;
		n = irq_n;
		cmd(o, c, lba);
		for (int s = 0; s < ns; s++) begin
			for (int k = 0; k < 5000 && (dma ? dmarq : drq) !== 1'b1; k++) @(negedge clk);
			awsc_host_model_i.send_words(dma, 16'h1000);
			// the last word lands a few cycles after the pin edge; let the request drop first
			for (int k = 0; k < 50 && drq === 1'b1; k++) @(negedge clk);
		end
	endtask
	task automatic report_and_stop;
		if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ************************************************
	// sequence
	// ************************************************
	initial begin
		arst_n = 1'b0;
		cmd_v = 1'b0;
		x8 = 1'b0;
		{op, cnt, dh, chi, clo, snum} = 48'h0;
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		chk("reset state", 28'h0, {bsy, drq, dmarq, irq, err, abrt, slp, men, bsz});
		chk("id block max", 28'h1, idmax);
		repeat (4) @(negedge clk);
		foreach (rows[i]) begin
			x8 = rows[i].x8;
			n = irq_n;
			cmd(rows[i].op, rows[i].cnt, 28'h5a5a5a5);
			wait_irq(n + 1);
			chk("abort", rows[i].abrt, abrt);
			chk("error", rows[i].abrt, err);
			chk("sleep", rows[i].slp, slp);
			chk("mult enable", rows[i].men, men);
			if (rows[i].op == 8'h87) chk("translate count", 28'h0, o_cnt);
		end
		x8 = 1'b0;
		chk("block size", 28'h1, bsz);
		bufs = 0;
		run(8'he8, 8'h00, 1, 1'b0, 28'h0, -1);
		wait_irq(n + 1);
		chk("buffer words", 28'd256, 28'(bufs));
		chk("buffer last", 28'h0ff10ff, {4'h0, la, ld});
		chk("buffer commits", 28'h0, 28'(sec_idx));
		run(8'hca, 8'h02, 2, 1'b1, 28'h1234567, -1);
		wait_irq(n + 1);
		chk("dma first lba", 28'h1234567, fl);
		chk("dma end addr", 28'h1234568, {o_dh[3:0], o_chi, o_clo, o_snum});
		chk("dma status", 28'h0e00, {err, o_dh[7:4], o_cnt});
		run(8'hca, 8'h03, 1, 1'b1, 28'h0000040, 0);
		wait_irq(n + 1);
		chk("dma fail addr", 28'h0000040, {o_dh[3:0], o_chi, o_clo, o_snum});
		chk("dma fail err", 28'h1, err);
		run(8'hc5, 8'h02, 2, 1'b0, 28'h0000010, 1);
		wait_irq(n + 2);
		chk("mult fail addr", 28'h0000011, {o_dh[3:0], o_chi, o_clo, o_snum});
		chk("mult residue", 28'h201, {err, ne, o_cnt});
		// residue is nonzero here, so translate must really clear it
		n = irq_n;
		cmd(8'h87, 8'h05, 28'h5a5a5a5);
		wait_irq(n + 1);
		chk("translate clears count", 28'h0, o_cnt);
		run(8'hcd, 8'h01, 1, 1'b0, 28'h0000020, -1);
		wait_irq(n + 1);
		chk("no erase", 28'h1, ne);
		chk("no erase addr", 28'h0000020, {o_dh[3:0], o_chi, o_clo, o_snum});
		report_and_stop();
	end
	// ************************************************
	// watchdog, well past the expected run length
	// ************************************************
	initial begin
		#500000;
		fails++;
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
